// ### shared/srsi_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SRSI_DEFINES_SVH
`define SRSI_DEFINES_SVH
// =====================================================================
// Register map (byte addresses)
`define SRSI_OFS_CONTROL 12'h000
`define SRSI_OFS_SCAN 12'h004
`define SRSI_OFS_MCLK 12'h008
`define SRSI_MOD_REGION 2'h1
// =====================================================================
// Control/status field positions
`define SRSI_B_RFC 0
`define SRSI_B_DEF_IEN 1
`define SRSI_B_IM_IEN 2
`define SRSI_B_DEF_SEN 3
`define SRSI_B_IM_SEN 4
`define SRSI_B_DEF_DONE 5
`define SRSI_B_IM_DONE 7
`define SRSI_B_MSTP_X 8
`define SRSI_B_MSTP_Y 9
`define SRSI_B_MSTP_W 10
`define SRSI_B_MMODE 11
`define SRSI_B_PWR_FAIL 14
`define SRSI_B_SCAN_ERR 15
`define SRSI_B_DEFERRED_RESULT_INVALID 15
// =====================================================================
// Reset values and constants
`define SRSI_CTRL_RESET 8'h00
`define SRSI_SCAN_ALL_ONES 8'hFF
`define SRSI_VECTOR 8'h9C
// =====================================================================
// Timing: scan clock period and system clock period
`define SRSI_SCAN_PERIOD_NS 1000
`define SRSI_CLK_PERIOD_NS 25
`define SRSI_SCAN_TICK_CYC (`SRSI_SCAN_PERIOD_NS / `SRSI_CLK_PERIOD_NS)
`endif

// ### shared/srsi_pkg.sv
// Types shared by the service request scan interrupt block.
package srsi_pkg;
   // =================================================================
   // Scanner address: X code, Y code and word index.
   typedef struct packed {
      logic [2:0] x;
      logic [2:0] y;
      logic [1:0] word_index;
   } srsi_scan_addr_t;

   // Writable control fields of the control/status register.
   typedef struct packed {
      logic maint_mode;
      logic maint_stop_word;
      logic maint_stop_y;
      logic maint_stop_x;
      logic immediate_scan_enable;
      logic deferred_scan_enable;
      logic immediate_irq_enable;
      logic deferred_irq_enable;
      logic request_flag_clear;
   } srsi_ctrl_t;

   // Which request type owns the current scan.
   typedef enum logic [1:0] {
      SRSI_IDLE,
      SRSI_SCAN_DEF,
      SRSI_SCAN_IM
   } srsi_state_t;
endpackage

// ### verilog/srsi_scan_irq.sv
// Service request arbitration, address scanner and bus request logic.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "srsi_defines.svh"

// What this block does
// - Control bits 01-04 enable interrupts and scans.
// - Scan found sets deferred or immediate done.
// - Done with interrupt enable raises level request.
// - Immediate request aborts deferred scan in progress.
// - Immediate start after deferred done flags invalid.
// - Requests set busy only when enabled, no PIO.
// - Busy during scan; stop clears busy, sets done.
// - Data read without clear keeps done, which blocks a rescan of its own type.
// - Data read with clear drops done, module flag.
// - Toggling interrupt enables clears done, rescans.
// - Module address from bus during PIO, else scanner.
// - Register accesses keep scanner address routed.
// - Counters X, Y, word stop on field matches.
// - Start pulse clears counters, deferred past PIO.
// - One-microsecond scan clock steered field by field.
// - Each maintenance clock access gives one pulse.
// - Maintenance stop bits freeze counter, advance next.
// - Maintenance mode forces a request, scanner overflows.
// - Overflow sets scan error, address all ones.
// - Power fail sets its flag, address all ones.
// - Fixed vector is driven at all times; there is no bus grant input.
module srsi_scan_irq #(
   parameter int TICK_CYCLES = `SRSI_SCAN_TICK_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Avalon-MM slave.
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // I/O module side.
   input wire logic module_immediate_request,
   input wire logic module_deferred_request,
   input wire logic match_x,
   input wire logic match_y,
   input wire logic match_word,
   input wire logic [15:0] module_rdata,
   output logic [7:0] file_addr,
   output logic prog_io_addr_select,
   output logic module_read,
   output logic module_write,
   output logic [15:0] module_wdata,
   output logic module_flag_clear,
   input wire logic power_fail,
   // Host bus request side.
   output logic bus_request_4,
   output logic bus_request_6,
   output logic [7:0] irq_vector
);

   // ==================================================================
   // State
   srsi_pkg::srsi_ctrl_t ctrl_q;
   srsi_pkg::srsi_scan_addr_t scan_q;
   srsi_pkg::srsi_state_t state_q;
   logic def_busy_q, im_busy_q, def_done_q, im_done_q;
   logic deferred_result_invalid_q, scan_err_q, pwr_fail_q, pwr_prev_q;
   logic start_pend_q, ien_off_q, ack_q;
   logic [31:0] rdata_q;
   logic [15:0] wdata_q;
   logic [6:0] tick_q;
   logic [31:0] rd_mux;

   // ==================================================================
   // Bus decode
   // Every request waits exactly one cycle; effects land on the ack edge.
   wire req = avs_read | avs_write;
   wire acc = req & ack_q;
   wire in_mod = avs_address[11:10] == `SRSI_MOD_REGION;
   wire sel_ctrl = avs_address == `SRSI_OFS_CONTROL;
   wire sel_scan = avs_address == `SRSI_OFS_SCAN;
   wire sel_mclk = avs_address == `SRSI_OFS_MCLK;
   wire lo_lanes = &avs_byteenable[1:0];
   wire wr_ctrl = acc & avs_write & sel_ctrl & lo_lanes;
   wire wr_clr = acc & avs_write & sel_ctrl & avs_byteenable[1];
   wire mod_rd_ack = acc & avs_read & in_mod;
   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata = rdata_q;

   // address mux
   // Only module-region traffic is programmed I/O to a module.
   wire prog_io = req & in_mod;
   // scanner routed
   // Register and maintenance accesses leave the scanner on the file.
   assign prog_io_addr_select = prog_io;
   assign file_addr = prog_io ? avs_address[9:2] : scan_q;
   assign module_read = avs_read & in_mod & ~ack_q;
   assign module_write = acc & avs_write & in_mod;
   assign module_wdata = wdata_q;

   // ==================================================================
   // Request arbitration
   // forced request
   wire im_raw = module_immediate_request |
                 (ctrl_q.maint_mode & ctrl_q.immediate_irq_enable);
   wire def_raw = module_deferred_request |
                  (ctrl_q.maint_mode & ctrl_q.deferred_irq_enable);
   wire im_req = im_raw & ctrl_q.immediate_scan_enable;
   wire def_req = def_raw & ctrl_q.deferred_scan_enable;
   // immediate preempts
   // Deferred busy does not block an immediate start; it is abandoned.
   wire im_go = im_req & ~im_busy_q & ~im_done_q & ~prog_io;
   wire def_go = def_req & ~def_busy_q & ~def_done_q & ~prog_io &
                 ~im_go & ~im_busy_q;
   // start pulse
   // A start seen during programmed I/O waits until the access ends.
   wire start_now = (im_go | def_go | start_pend_q) & ~prog_io;
   wire start_hold = prog_io & (start_pend_q |
                     (im_req & ~im_busy_q & ~im_done_q));

   // ==================================================================
   // Scanner stepping
   wire active_im = state_q == srsi_pkg::SRSI_SCAN_IM;
   wire active_def = state_q == srsi_pkg::SRSI_SCAN_DEF;
   wire sen = (active_im & ctrl_q.immediate_scan_enable) |
              (active_def & ctrl_q.deferred_scan_enable);
   wire stop_x = (match_x & sen) | ctrl_q.maint_stop_x;
   wire stop_y = (match_y & sen) | ctrl_q.maint_stop_y;
   wire stop_w = (match_word & sen) | ctrl_q.maint_stop_word;
   wire scan_stopped = stop_x & stop_y & stop_w;
   wire tick = tick_q == 7'(TICK_CYCLES - 1);
   // scan clock
   // The timed clock is held off while programmed I/O owns the file.
   wire run_clk = (active_im | active_def) & tick & ~prog_io &
                  ~start_now;
   wire mclk = acc & sel_mclk;
   wire pulse = (run_clk | mclk) & ~scan_stopped;
   wire adv_x = pulse & ~stop_x;
   wire adv_y = pulse & stop_x & ~stop_y;
   wire adv_w = pulse & stop_x & stop_y & ~stop_w;
   // overflow
   // Stepping a field that is already at its top has no module to find.
   wire overflow = (adv_x & (&scan_q.x)) | (adv_y & (&scan_q.y)) |
                   (adv_w & (&scan_q.word_index));
   wire found = (active_im | active_def) & scan_stopped & ~start_now &
                ~prog_io;
   wire pwr_evt = power_fail & ~pwr_prev_q;

   // ==================================================================
   // Done clearing
   // read keeps done
   wire rfc_read = mod_rd_ack & ctrl_q.request_flag_clear;
   wire clr_im_done = rfc_read & im_done_q;
   wire clr_def_done = rfc_read & ~im_done_q;
   wire new_ien = avs_writedata[`SRSI_B_DEF_IEN] |
                  avs_writedata[`SRSI_B_IM_IEN];
   wire ien_retrig = wr_ctrl & ien_off_q & new_ien;

   // ==================================================================
   // Bus handshake and read data capture.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         wdata_q <= 16'h0000;
      end else if (ce) begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            rdata_q <= rd_mux;
         end
         if (avs_write & in_mod & ~ack_q) begin
            wdata_q <= avs_writedata[15:0];
         end
      end
   end

   // Read mux: control, scan, module data; others read zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_mux[8:0] = {ctrl_q.maint_mode, ctrl_q.maint_stop_word,
                        ctrl_q.maint_stop_y, ctrl_q.maint_stop_x,
                        1'b0, 1'b0, 1'b0, 1'b0, 1'b0} |
                       9'({ctrl_q.immediate_scan_enable,
                           ctrl_q.deferred_scan_enable,
                           ctrl_q.immediate_irq_enable,
                           ctrl_q.deferred_irq_enable,
                           ctrl_q.request_flag_clear} >> 0);
         rd_mux[8:0] = {ctrl_q.maint_mode, ctrl_q.maint_stop_word,
                        ctrl_q.maint_stop_y, ctrl_q.maint_stop_x,
                        ctrl_q.immediate_scan_enable,
                        ctrl_q.deferred_scan_enable,
                        ctrl_q.immediate_irq_enable,
                        ctrl_q.deferred_irq_enable,
                        ctrl_q.request_flag_clear};
         rd_mux[11:8] = {ctrl_q.maint_mode, ctrl_q.maint_stop_word,
                         ctrl_q.maint_stop_y, ctrl_q.maint_stop_x};
         rd_mux[`SRSI_B_DEF_DONE] = def_done_q;
         rd_mux[`SRSI_B_IM_DONE] = im_done_q;
         rd_mux[6] = 1'b0;
         rd_mux[`SRSI_B_PWR_FAIL] = pwr_fail_q;
         rd_mux[`SRSI_B_SCAN_ERR] = scan_err_q;
      end else if (sel_scan) begin
         rd_mux[7:0] = scan_q;
         rd_mux[`SRSI_B_DEFERRED_RESULT_INVALID] = deferred_result_invalid_q;
      end else if (in_mod) begin
         rd_mux[15:0] = module_rdata;
      end
   end

   // ==================================================================
   // Control register; done bits cannot be written, error bits can only be cleared.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= '0;
         ien_off_q <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_q <= {avs_writedata[`SRSI_B_MMODE],
                       avs_writedata[`SRSI_B_MSTP_W],
                       avs_writedata[`SRSI_B_MSTP_Y],
                       avs_writedata[`SRSI_B_MSTP_X],
                       avs_writedata[`SRSI_B_IM_SEN:`SRSI_B_RFC]};
            ien_off_q <= ~new_ien;
         end
      end
   end

   // ==================================================================
   // Scan state, busy flags and pending start.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= srsi_pkg::SRSI_IDLE;
         im_busy_q <= 1'b0;
         def_busy_q <= 1'b0;
         start_pend_q <= 1'b0;
      end else if (ce) begin
         start_pend_q <= start_hold;
         if (im_go) begin
            state_q <= srsi_pkg::SRSI_SCAN_IM;
            im_busy_q <= 1'b1;
            def_busy_q <= 1'b0;
         end else if (def_go) begin
            state_q <= srsi_pkg::SRSI_SCAN_DEF;
            def_busy_q <= 1'b1;
         end else if (found | (overflow & ~found)) begin
            state_q <= srsi_pkg::SRSI_IDLE;
            im_busy_q <= 1'b0;
            def_busy_q <= 1'b0;
         end
      end
   end

   // Done flags: hardware set wins over any clear in the same cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         im_done_q <= 1'b0;
         def_done_q <= 1'b0;
         deferred_result_invalid_q <= 1'b0;
      end else if (ce) begin
         if (found & active_im) begin
            im_done_q <= 1'b1;
         end else if (clr_im_done | ien_retrig) begin
            im_done_q <= 1'b0;
         end
         if (found & active_def) begin
            def_done_q <= 1'b1;
         end else if (clr_def_done | ien_retrig) begin
            def_done_q <= 1'b0;
         end
         if (im_go & def_done_q) begin
            deferred_result_invalid_q <= 1'b1;
         end else if (~im_done_q & ~def_done_q) begin
            deferred_result_invalid_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Scanner counters and the microsecond divider.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scan_q <= '0;
         tick_q <= 7'h00;
      end else if (ce) begin
         tick_q <= (tick | start_now) ? 7'h00 : tick_q + 7'h01;
         if (overflow | pwr_evt) begin
            scan_q <= `SRSI_SCAN_ALL_ONES;
         end else if (start_now) begin
            scan_q <= '0;
         end else if (adv_x) begin
            scan_q.x <= scan_q.x + 3'h1;
         end else if (adv_y) begin
            scan_q.y <= scan_q.y + 3'h1;
         end else if (adv_w) begin
            scan_q.word_index <= scan_q.word_index + 2'h1;
         end
      end
   end

   // Error flags are write-one-to-clear; a new event wins.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scan_err_q <= 1'b0;
         pwr_fail_q <= 1'b0;
         pwr_prev_q <= 1'b0;
      end else if (ce) begin
         pwr_prev_q <= power_fail;
         if (overflow) begin
            scan_err_q <= 1'b1;
         end else if (wr_clr & avs_writedata[`SRSI_B_SCAN_ERR]) begin
            scan_err_q <= 1'b0;
         end
         if (pwr_evt) begin
            pwr_fail_q <= 1'b1;
         end else if (wr_clr & avs_writedata[`SRSI_B_PWR_FAIL]) begin
            pwr_fail_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Module flag clear and bus requests.
   // module flag
   assign module_flag_clear = rfc_read;
   // shared vector
   // Both levels share one vector, so software must check the done bits.
   wire any_ien = ctrl_q.immediate_irq_enable | ctrl_q.deferred_irq_enable;
   assign bus_request_4 = def_done_q & ctrl_q.deferred_irq_enable;
   assign bus_request_6 = (im_done_q & ctrl_q.immediate_irq_enable) |
                          ((scan_err_q | pwr_fail_q) & any_ien);
   assign irq_vector = `SRSI_VECTOR;
endmodule

// ### test/srsi_scan_irq_checker.sv
// Port-level assertions for the service request scan interrupt block.
`timescale 1ns/1ps
`include "srsi_defines.svh"
module srsi_scan_irq_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [7:0] file_addr,
   input wire logic prog_io_addr_select,
   input wire logic module_read,
   input wire logic module_write,
   input wire logic module_flag_clear,
   input wire logic bus_request_4,
   input wire logic bus_request_6,
   input wire logic [7:0] irq_vector
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // =================================================================
   // Decode helpers
   // A control read is judged only on its ack cycle, when data stand.
   wire logic req = avs_read | avs_write;
   wire logic mod_sel = avs_address[11:10] == 2'h1;
   wire logic ctl_rd = avs_read & !avs_waitrequest & (avs_address == 12'h000);
   // =================================================================
   // Assertions
   AST_ONE_WAIT: assert property (
      $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait state count wrong");
   AST_PIO_ADDR: assert property (
      prog_io_addr_select |-> file_addr == avs_address[9:2])
      else $error("file address not from bus");
   AST_MOD_PIO: assert property (
      req && mod_sel |-> prog_io_addr_select)
      else $error("module access not selected");
   AST_REG_ROUTE: assert property (
      req && !mod_sel |-> !prog_io_addr_select)
      else $error("register access stole address");
   AST_BR4: assert property (
      ctl_rd && avs_readdata[5] && avs_readdata[1] |-> bus_request_4)
      else $error("level 4 request missing");
   AST_BR4_OFF: assert property (
      ctl_rd && !avs_readdata[1] |-> !bus_request_4)
      else $error("level 4 request without enable");
   AST_BR6: assert property (
      ctl_rd && avs_readdata[7] && avs_readdata[2] |-> bus_request_6)
      else $error("level 6 request missing");
   AST_FLAG_CLR: assert property (
      module_flag_clear |-> avs_read && !avs_waitrequest && mod_sel)
      else $error("flag clear outside module read");
   AST_MREAD: assert property (
      module_read |-> avs_read && avs_waitrequest && mod_sel ##1 !module_read)
      else $error("module read pulse wrong");
   AST_MWRITE: assert property (
      module_write |-> avs_write && !avs_waitrequest && mod_sel)
      else $error("module write pulse wrong");
   AST_VECTOR: assert property (irq_vector == `SRSI_VECTOR)
      else $error("vector wrong");
   C_BR4: cover property (bus_request_4);
   C_BR6: cover property (bus_request_6);
   C_CLR: cover property (module_flag_clear);
endmodule

bind srsi_scan_irq srsi_scan_irq_checker chk (.clk(clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .file_addr(file_addr), .prog_io_addr_select(prog_io_addr_select),
   .module_read(module_read), .module_write(module_write),
   .module_flag_clear(module_flag_clear), .bus_request_4(bus_request_4),
   .bus_request_6(bus_request_6), .irq_vector(irq_vector));

// ### test/srsi_module_model.sv
// Behavioural model of one requesting I/O module with its stop logic.
`timescale 1ns/1ps
module srsi_module_model #(
   parameter logic [15:0] DATA = 16'h5A3C
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] target,
   input wire logic raise_im,
   input wire logic raise_def,
   input wire logic [7:0] file_addr,
   input wire logic module_read,
   input wire logic module_flag_clear,
   output logic module_immediate_request,
   output logic module_deferred_request,
   output logic match_x,
   output logic match_y,
   output logic match_word,
   output logic [15:0] module_rdata
);
   logic req_im_q;
   logic req_def_q;
   // flag clear
   // Request flags persist until a clearing read, as on real modules.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_im_q <= 1'b0;
         req_def_q <= 1'b0;
      end else if (module_flag_clear) begin
         req_im_q <= 1'b0;
         req_def_q <= 1'b0;
      end else begin
         req_im_q <= req_im_q | raise_im;
         req_def_q <= req_def_q | raise_def;
      end
   end
   // field stop logic
   // Matches only while a request stands, so an idle module never stops.
   wire logic any_req = req_im_q | req_def_q;
   assign module_immediate_request = req_im_q;
   assign module_deferred_request = req_def_q;
   assign match_x = any_req & (file_addr[7:5] == target[7:5]);
   assign match_y = any_req & (file_addr[4:2] == target[4:2]);
   assign match_word = any_req & (file_addr[1:0] == target[1:0]);
   // Unselected data lines show the inverse so stale data never passes.
   assign module_rdata = module_read ? DATA : ~DATA;
endmodule

// ### test/srsi_scan_irq_bench.sv
// Self-checking bench for the service request scan interrupt block.
`timescale 1ns/1ps
module srsi_scan_irq_bench;
   logic clk, rst_b, avs_read, avs_write, avs_waitrequest, power_fail;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic mir, mdr, mx, my, mw, prog_sel, mrd, mwr, mclr, br4, br6;
   logic raise_im, raise_def;
   logic [15:0] mrdata, mwdata;
   logic [7:0] faddr, vec;
   int miscompares = 0;
   int checks = 0;
   localparam logic [11:0] MA = 12'h5D8;
   srsi_scan_irq #(.TICK_CYCLES(4)) dut (.clk(clk), .rst_b(rst_b),
      .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .module_immediate_request(mir),
      .module_deferred_request(mdr), .match_x(mx), .match_y(my),
      .match_word(mw), .module_rdata(mrdata), .file_addr(faddr),
      .prog_io_addr_select(prog_sel), .module_read(mrd),
      .module_write(mwr), .module_wdata(mwdata),
      .module_flag_clear(mclr), .power_fail(power_fail),
      .bus_request_4(br4), .bus_request_6(br6), .irq_vector(vec));
   srsi_module_model mdl (.clk(clk), .rst_b(rst_b), .target(8'h76),
      .raise_im(raise_im), .raise_def(raise_def), .file_addr(faddr),
      .module_read(mrd), .module_flag_clear(mclr),
      .module_immediate_request(mir), .module_deferred_request(mdr),
      .match_x(mx), .match_y(my), .match_word(mw), .module_rdata(mrdata));
   // =================================================================
   // Shared tasks
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The request is held until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [15:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      if (n >= 20) check(32'h0, 32'h1);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      bus(1'b0, a, 16'h0000, q);
   endtask
   task automatic wait_br(input int lvl);
      int n;
      n = 0;
      while ((lvl == 6 ? br6 : br4) !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n >= 300) check(32'h0, 32'h1);
   endtask
   task automatic pulse(input logic im);
      @(posedge clk);
      if (im) raise_im <= 1'b1;
      else raise_def <= 1'b1;
      @(posedge clk);
      raise_im <= 1'b0;
      raise_def <= 1'b0;
   endtask
   // =================================================================
   // Scenarios
   task automatic t_maint();
      logic [31:0] q;
      repeat (5) rd(12'h008, q);
      rd(12'h004, q);
      check(q, 32'h000000A0);
      wr(12'h000, 16'h0100);
      rd(12'h008, q);
      rd(12'h004, q);
      check(q, 32'h000000A4);
      wr(12'h000, 16'h0000);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      wr(12'h000, 16'h001E);
      rd(12'h000, q);
      check(q, 32'h0000001E);
      wr(12'h000, 16'h00A0);
      rd(12'h000, q);
      check(q, 32'h00000000);
      wr(MA, 16'h1234);
      check({16'h0000, mwdata}, 32'h00001234);
      wr(12'h00C, 16'hFFFF);
      rd(12'h00C, q);
      check(q, 32'h00000000);
   endtask
   task automatic t_noscan();
      wr(12'h000, 16'h0002);
      pulse(1'b0);
      repeat (100) @(posedge clk);
      check({31'h0, br4}, 32'h0);
   endtask
   task automatic t_deferred();
      logic [31:0] q;
      wr(12'h000, 16'h000A);
      wait_br(4);
      check({31'h0, br4}, 32'h1);
      rd(12'h004, q);
      check(q, 32'h00000076);
      rd(12'h000, q);
      check(q, 32'h0000002A);
      rd(MA, q);
      check(q, 32'h00005A3C);
      rd(12'h000, q);
      check(q, 32'h0000002A);
      wr(12'h000, 16'h000B);
      rd(MA, q);
      rd(12'h000, q);
      check(q, 32'h0000000B);
   endtask
   task automatic t_displace();
      logic [31:0] q;
      wr(12'h000, 16'h001E);
      pulse(1'b0);
      wait_br(4);
      pulse(1'b1);
      wait_br(6);
      check({31'h0, br6}, 32'h1);
      rd(12'h004, q);
      check(q, 32'h00008076);
      rd(12'h000, q);
      check(q & 32'h80, 32'h80);
      wr(12'h000, 16'h0018);
      wr(12'h000, 16'h001E);
      rd(12'h000, q);
      check(q, 32'h0000001E);
      rd(12'h004, q);
      check(q & 32'h8000, 32'h0);
      wait_br(6);
      check({31'h0, br6}, 32'h1);
      wr(12'h000, 16'h001F);
      rd(MA, q);
      rd(12'h000, q);
      check(q & 32'h80, 32'h0);
      wr(12'h000, 16'h0000);
   endtask
   task automatic t_faults();
      logic [31:0] q;
      wr(12'h000, 16'h0814);
      wait_br(6);
      // The forced request rescans one cycle after overflow, so the
      // all-ones address is only visible on the file address now.
      check({24'h0, faddr}, 32'h000000FF);
      rd(12'h000, q);
      check(q & 32'h8000, 32'h8000);
      wr(12'h000, 16'h8000);
      // The running scan overflows once more; let it idle, then clear.
      repeat (200) @(posedge clk);
      wr(12'h000, 16'h8000);
      wr(12'h000, 16'h0004);
      power_fail <= 1'b1;
      wait_br(6);
      rd(12'h000, q);
      check(q & 32'hC000, 32'h4000);
      rd(12'h004, q);
      check(q & 32'hFF, 32'hFF);
      power_fail <= 1'b0;
   endtask
   // =================================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      rst_b = 1'b0;
      {avs_read, avs_write, power_fail, raise_im, raise_def} = 5'h00;
      avs_address = 12'h000;
      avs_writedata = 32'h00000000;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_maint();
      t_regs();
      t_noscan();
      t_deferred();
      t_displace();
      t_faults();
      report_and_stop();
   end
   // The full sequence needs under a thousand cycles; this is ample.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
endmodule
